// ### hdl/phyirq_pkg.sv
package phyirq_pkg;

  // management register addresses
  localparam logic [4:0] ADDR_IRQ_MASK = 5'h18;
  localparam logic [4:0] ADDR_IRQ_STATUS = 5'h19;
  localparam logic [4:0] ADDR_LIVE_STATUS = 5'h1A;

  // reset values
  localparam logic [10:0] IRQ_MASK_RESET = 11'h000;
  localparam logic [10:0] IRQ_STATUS_RESET = 11'h000;
  localparam logic [15:0] LIVE_STATUS_RESET = 16'h0300;

  // field positions
  localparam int EVENT_COUNT = 10;
  localparam int MASK_WIDTH = 11;
  localparam int MASK_PIN_BIT = 0;
  localparam int IRQ_PENDING_BIT = 0;
  localparam int LIVE_STANDBY_BIT = 15;
  localparam int LIVE_LINK_BIT = 6;
  localparam int LIVE_TXEN_BIT = 5;
  localparam int LIVE_BOTH_AN_BIT = 2;
  localparam int LIVE_TECH_LSB = 7;

  // resolved technology codes
  localparam logic [2:0] TECH_100_FULL = 3'h3;
  localparam logic [2:0] TECH_100_HALF = 3'h2;
  localparam logic [2:0] TECH_10_FULL = 3'h1;
  localparam logic [2:0] TECH_10_HALF = 3'h0;

  // management frame fields
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [5:0] PREAMBLE_BITS = 6'h20;
  localparam logic [5:0] HEADER_LAST = 6'h0B;
  localparam logic [5:0] DATA_LAST = 6'h0F;

  typedef enum logic [2:0] {SM_PRE, SM_START, SM_HDR, SM_TA, SM_DATA} phyirq_state_t;

  typedef struct packed {
    phyirq_state_t state;
    logic [5:0] count;
    logic [15:0] shift;
    logic isRead;
    logic selected;
    logic [4:0] regAddr;
    logic mdioOut;
    logic mdioOe;
    logic [10:0] mask;
    logic [15:0] live;
    logic interruptN;
    logic mdcPrev;
  } phyirq_top_t;

endpackage

// ### hdl/phyirq_evt_if.sv
`timescale 1ns/1ps
interface phyirq_evt_if #(parameter int N = 10);
  logic [N:1] events;
  logic [N:1] mask;
  logic clear;
  logic [N:0] status;

  modport owner (output events, output mask, output clear, input status);
  modport latch (input events, input mask, input clear, output status);
endinterface

// ### hdl/phyirq_sync.sv
`timescale 1ns/1ps
module phyirq_sync #(
  parameter int WIDTH = 2
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } phyirq_sync_t;

  phyirq_sync_t r;
  phyirq_sync_t n;

  always_comb begin
    n = r;
    n.stage1 = asyncIn;
    n.stage2 = r.stage1;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign syncOut = r.stage2;
endmodule

// ### hdl/phyirq_latch.sv
`timescale 1ns/1ps
module phyirq_latch #(
  parameter int N = 10
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  phyirq_evt_if.latch evt
);
  import phyirq_pkg::*;

  typedef struct packed {
    logic [N:1] stat;
    logic pend;
  } phyirq_latch_t;

  phyirq_latch_t r;
  phyirq_latch_t n;

  always_comb begin
    n = r;
    // a trigger in the clearing cycle survives the clear
    n.stat = (r.stat & ~{N{evt.clear}}) | evt.events; // [R01] [R02] [R03] [R23]
    n.pend = (r.pend & ~evt.clear) | (|(n.stat & evt.mask)); // [R04] [R07] [R21]
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= IRQ_STATUS_RESET;
    end else begin
      r <= n;
    end
  end

  assign evt.status = {r.stat, r.pend};

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_eventLatches;
    (evt.events != '0) |=> ((evt.status[N:1] & $past(evt.events)) == $past(evt.events));
  endproperty
  a_eventLatches: assert property (p_eventLatches) else $error("event not latched"); // [R23]

  property p_holdUntilRead;
    !evt.clear |=> (($past(evt.status[N:1]) & ~evt.status[N:1]) == '0);
  endproperty
  a_holdUntilRead: assert property (p_holdUntilRead) else $error("status bit lost"); // [R01]

  property p_clearAll;
    (evt.clear && evt.events == '0) |=> (evt.status == '0);
  endproperty
  a_clearAll: assert property (p_clearAll) else $error("clear left bits set"); // [R02]

  property p_maskedStillLatch;
    ((evt.events & ~evt.mask) != '0) |=>
      ((evt.status[N:1] & $past(evt.events & ~evt.mask)) == $past(evt.events & ~evt.mask));
  endproperty
  a_maskedStillLatch: assert property (p_maskedStillLatch) else $error("masked bit not set"); // [R03]

  property p_pendOnlyEnabled;
    (!evt.status[0] && ((evt.status[N:1] | evt.events) & evt.mask) == '0) |=> !evt.status[0];
  endproperty
  a_pendOnlyEnabled: assert property (p_pendOnlyEnabled) else $error("pending from masked"); // [R04]

  property p_pendHolds;
    (evt.status[0] && !evt.clear) |=> evt.status[0];
  endproperty
  a_pendHolds: assert property (p_pendHolds) else $error("pending dropped early"); // [R07]
endmodule

// ### hdl/phyirq_top.sv
`timescale 1ns/1ps
// Functional notes
// (R01) status bits latch on trigger until read
// (R02) reading interrupt status clears every bit
// (R03) bits latch even when masked
// (R04) pending counts only enabled latched bits
// (R05) bits 10..6 latch diag, sync, autoneg, checker, page
// (R06) bits 5..1 latch idle, fifo, receive, link, speed
// (R07) bit 0 pending, held until read
// (R08) bit 15 shows standby state
// (R09) bit 13 copies parallel fault, no clear
// (R10) bit 12 copies autoneg_complete_flag, no clear
// (R11) bit 11 shows pair swap
// (R12) bit 10 shows inverted 10BASE-T polarity
// (R13) bits 9..7 give resolved technology code
// (R14) bit 6 shows link up
// (R15) bit 5 shows transmit enable
// (R16) bit 4 shows receive data valid
// (R17) bit 3 shows collision
// (R18) bit 2 set when both ends negotiate
// (R19) bit 1 copies partner pause ability
// (R20) bit 0 copies partner asymmetric pause ability
// (R21) mask bits align with status bits
// (R22) pin enable gates active-low interrupt output
// (R23) trigger during clearing read stays latched
// (R24) reserved bits zero, read-only writes ignored
module phyirq_top #(
  parameter logic [4:0] PHY_ADDR = 5'h00
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe,
  output logic interruptN,
  input wire logic cableDiagEvent,
  input wire logic mgmtSyncLossEvent,
  input wire logic autonegChangeEvent,
  input wire logic frameCheckerEvent,
  input wire logic pageReceivedEvent,
  input wire logic idleErrorSaturatedEvent,
  input wire logic fifoOverUnderEvent,
  input wire logic receiveChangeEvent,
  input wire logic linkChangeEvent,
  input wire logic speedChangeEvent,
  input wire logic standbyFlag,
  input wire logic parallelDetectFaultFlag,
  input wire logic autonegCompleteFlag,
  input wire logic pairSwapDetected,
  input wire logic tenPolarityInverted,
  input wire logic [2:0] resolvedTechnology,
  input wire logic linkUp,
  input wire logic txEnActive,
  input wire logic receiveValidSeen,
  input wire logic collisionActive,
  input wire logic localAutonegAble,
  input wire logic partnerAutonegAble,
  input wire logic partnerAbilityPause,
  input wire logic partnerAbilityAsymPause
);
  import phyirq_pkg::*;

  phyirq_top_t r;
  phyirq_top_t n;
  phyirq_evt_if #(.N(EVENT_COUNT)) evt ();

  logic [1:0] pinSync;
  logic mdcS;
  logic mdioS;
  logic mdcRise;
  logic clearStatus;
  logic writeDone;
  logic [15:0] liveWord;
  logic [15:0] readWord;
  logic [11:0] header;

  phyirq_sync #(.WIDTH(2)) u_pinSync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .asyncIn({mdc, mdioIn}),
    .syncOut(pinSync)
  );

  phyirq_latch #(.N(EVENT_COUNT)) u_latch (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .evt(evt.latch)
  );

  assign mdcS = pinSync[1];
  assign mdioS = pinSync[0];
  assign mdcRise = mdcS & ~r.mdcPrev;

  // event order: bit 10 down to bit 1
  assign evt.events = {cableDiagEvent, mgmtSyncLossEvent, autonegChangeEvent, // [R05]
                       frameCheckerEvent, pageReceivedEvent,
                       idleErrorSaturatedEvent, fifoOverUnderEvent, // [R06]
                       receiveChangeEvent, linkChangeEvent, speedChangeEvent};
  assign evt.mask = r.mask[EVENT_COUNT:1]; // [R21]
  assign evt.clear = clearStatus;

  // live status word, reserved bit 14 held low
  always_comb begin
    liveWord = {standbyFlag, 1'b0, // [R08] [R24]
                parallelDetectFaultFlag, // [R09]
                autonegCompleteFlag, // [R10]
                pairSwapDetected, // [R11]
                tenPolarityInverted, // [R12]
                resolvedTechnology, // [R13]
                linkUp, // [R14]
                txEnActive, // [R15]
                receiveValidSeen, // [R16]
                collisionActive, // [R17]
                localAutonegAble & partnerAutonegAble, // [R18]
                partnerAbilityPause, // [R19]
                partnerAbilityAsymPause}; // [R20]
  end

  // read mux; upper bits of status and mask read zero
  always_comb begin
    readWord = 16'h0000;
    if (r.regAddr == ADDR_IRQ_MASK) begin
      readWord = {5'h00, r.mask};
    end else if (r.regAddr == ADDR_IRQ_STATUS) begin
      readWord = {5'h00, evt.status}; // [R24]
    end else if (r.regAddr == ADDR_LIVE_STATUS) begin
      readWord = r.live;
    end
  end

  assign header = {r.shift[10:0], mdioS};

  always_comb begin
    n = r;
    clearStatus = 1'b0;
    writeDone = 1'b0;
    n.mdcPrev = mdcS;
    n.live = liveWord;
    n.interruptN = ~(r.mask[MASK_PIN_BIT] & evt.status[IRQ_PENDING_BIT]); // [R22]
    if (mdcRise) begin
      unique case (r.state)
        SM_PRE: begin
          if (mdioS) begin
            if (r.count != PREAMBLE_BITS) begin
              n.count = r.count + 6'h01;
            end
          end else if (r.count == PREAMBLE_BITS) begin
            n.state = SM_START;
            n.count = 6'h00;
          end else begin
            n.count = 6'h00;
          end
        end
        SM_START: begin
          n.count = 6'h00;
          n.state = mdioS ? SM_HDR : SM_PRE;
        end
        SM_HDR: begin
          n.shift = {r.shift[14:0], mdioS};
          n.count = r.count + 6'h01;
          if (r.count == HEADER_LAST) begin
            n.count = 6'h00;
            n.isRead = (header[11:10] == OP_READ);
            n.selected = (header[9:5] == PHY_ADDR);
            n.regAddr = header[4:0];
            if (header[11:10] == OP_READ || header[11:10] == OP_WRITE) begin
              n.state = SM_TA;
            end else begin
              n.state = SM_PRE;
            end
          end
        end
        SM_TA: begin
          if (r.count == 6'h00) begin
            n.count = 6'h01;
            if (r.isRead && r.selected) begin
              n.mdioOe = 1'b1;
              n.mdioOut = 1'b0;
            end
          end else begin
            n.state = SM_DATA;
            n.count = 6'h00;
            if (r.isRead && r.selected) begin
              n.shift = readWord;
              n.mdioOut = readWord[15];
              clearStatus = (r.regAddr == ADDR_IRQ_STATUS); // [R02]
            end
          end
        end
        SM_DATA: begin
          n.count = r.count + 6'h01;
          if (r.isRead) begin
            n.shift = {r.shift[14:0], 1'b0};
            n.mdioOut = r.shift[14];
          end else begin
            n.shift = {r.shift[14:0], mdioS};
          end
          if (r.count == DATA_LAST) begin
            n.state = SM_PRE;
            n.count = 6'h00;
            n.mdioOe = 1'b0;
            n.mdioOut = 1'b0;
            if (!r.isRead && r.selected) begin
              writeDone = 1'b1;
              // only the mask register takes writes
              if (r.regAddr == ADDR_IRQ_MASK) begin
                n.mask = {r.shift[9:0], mdioS}; // [R24]
              end
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '{state: SM_PRE, count: 6'h00, shift: 16'h0000, isRead: 1'b0,
             selected: 1'b0, regAddr: 5'h00, mdioOut: 1'b0, mdioOe: 1'b0,
             mask: IRQ_MASK_RESET, live: LIVE_STATUS_RESET, interruptN: 1'b1,
             mdcPrev: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign mdioOut = r.mdioOut;
  assign mdioOe = r.mdioOe;
  assign interruptN = r.interruptN;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_statusLoad;
    mdcRise && r.state == SM_TA && r.count == 6'h01 && r.isRead && r.selected;
  endsequence

  sequence s_irqStatusLoad;
    s_statusLoad and (r.regAddr == ADDR_IRQ_STATUS && evt.events == '0);
  endsequence

  property p_readClears;
    s_irqStatusLoad |=> (evt.status == '0) ##1 (r.shift[10:0] == $past(evt.status, 2));
  endproperty
  a_readClears: assert property (p_readClears) else $error("read did not clear"); // [R02]

  property p_liveNoClear;
    (s_statusLoad and r.regAddr == ADDR_LIVE_STATUS) |-> !clearStatus
      ##1 (($past(evt.status) & ~evt.status) == '0);
  endproperty
  a_liveNoClear: assert property (p_liveNoClear) else $error("live read cleared"); // [R09]

  property p_pinDisabled;
    !r.mask[MASK_PIN_BIT] |=> interruptN;
  endproperty
  a_pinDisabled: assert property (p_pinDisabled) else $error("pin active while off"); // [R22]

  property p_pinActive;
    (r.mask[MASK_PIN_BIT] && evt.status[IRQ_PENDING_BIT]) |=> !interruptN;
  endproperty
  a_pinActive: assert property (p_pinActive) else $error("pin not asserted"); // [R22]

  property p_roWriteIgnored;
    (writeDone && r.regAddr != ADDR_IRQ_MASK) |=> $stable(r.mask);
  endproperty
  a_roWriteIgnored: assert property (p_roWriteIgnored) else $error("read-only write took"); // [R24]

  property p_linkAndTx;
    (linkUp && txEnActive) |=> (r.live[LIVE_LINK_BIT] && r.live[LIVE_TXEN_BIT]);
  endproperty
  a_linkAndTx: assert property (p_linkAndTx) else $error("link or tx bit wrong"); // [R14]

  property p_bothNegotiate;
    (!localAutonegAble || !partnerAutonegAble) |=> !r.live[LIVE_BOTH_AN_BIT];
  endproperty
  a_bothNegotiate: assert property (p_bothNegotiate) else $error("negotiate bit wrong"); // [R18]

  property p_standbyTech;
    standbyFlag |=> r.live[LIVE_STANDBY_BIT]
      && r.live[LIVE_TECH_LSB +: 3] == $past(resolvedTechnology);
  endproperty
  a_standbyTech: assert property (p_standbyTech) else $error("standby or tech wrong"); // [R13]

  property p_reservedZero;
    s_statusLoad |=> (r.regAddr != ADDR_LIVE_STATUS) || !r.shift[14];
  endproperty
  a_reservedZero: assert property (p_reservedZero) else $error("reserved bit set"); // [R24]

  property p_activityBits;
    1'b1 |=> r.live[LIVE_TXEN_BIT -: 3] ==
      {$past(txEnActive), $past(receiveValidSeen), $past(collisionActive)};
  endproperty
  a_activityBits: assert property (p_activityBits) else $error("activity bits wrong"); // [R16] [R17]

  property p_pauseBits;
    1'b1 |=> r.live[LIVE_BOTH_AN_BIT - 1 -: 2] ==
      {$past(partnerAbilityPause), $past(partnerAbilityAsymPause)};
  endproperty
  a_pauseBits: assert property (p_pauseBits) else $error("pause bits wrong"); // [R19] [R20]

  property p_copyBits;
    1'b1 |=> r.live[LIVE_STANDBY_BIT - 2 -: 4] == {$past(parallelDetectFaultFlag),
      $past(autonegCompleteFlag), $past(pairSwapDetected), $past(tenPolarityInverted)};
  endproperty
  a_copyBits: assert property (p_copyBits) else $error("copied bits wrong"); // [R09] [R10] [R11] [R12]
endmodule

// ### tb/phyirq_mdio_host.sv
`timescale 1ns/1ps
module phyirq_mdio_host
  import phyirq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic mdioLine,
  output logic mdc,
  output logic hostOe,
  output logic hostBit,
  output logic readValid,
  output logic [15:0] readData,
  output logic [6:0] bitNo
);
  localparam int HALF = 8;
  logic sampled;

  initial begin
    mdc = 1'b0;
    hostOe = 1'b0;
    hostBit = 1'b0;
    readValid = 1'b0;
    readData = 16'h0000;
    bitNo = 7'h00;
  end

  task automatic waitClk(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // data set in the low phase, line sampled just before the rise
  task automatic clockBit(input logic b, input logic drive);
    mdc = 1'b0;
    hostOe = drive;
    hostBit = b;
    waitClk(HALF);
    sampled = mdioLine;
    mdc = 1'b1;
    waitClk(HALF);
    bitNo = bitNo + 7'h01;
  endtask

  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] regA,
                       input logic [15:0] wData);
    logic [13:0] hdr;
    logic [15:0] rData;
    hdr = {2'h1, op, phy, regA};
    rData = 16'h0000;
    bitNo = 7'h00;
    repeat (32) clockBit(1'b1, 1'b1);
    for (int i = 13; i >= 0; i--) clockBit(hdr[i], 1'b1);
    if (op == OP_READ) begin
      clockBit(1'b1, 1'b0);
      clockBit(1'b1, 1'b0);
      for (int i = 0; i < 16; i++) begin
        clockBit(1'b1, 1'b0);
        rData = {rData[14:0], sampled};
      end
    end else begin
      clockBit(1'b1, 1'b1);
      clockBit(1'b0, 1'b1);
      for (int i = 15; i >= 0; i--) clockBit(wData[i], 1'b1);
    end
    // clock stands still and line released between frames
    mdc = 1'b0;
    hostOe = 1'b0;
    if (op == OP_READ) begin
      readData = rData;
      readValid = 1'b1;
    end
    // one edge between frames, so no signal is set twice in one step
    waitClk(1);
    readValid = 1'b0;
  endtask
endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
  import phyirq_pkg::*;
  typedef struct {logic [15:0] value; logic [15:0] care;} phyirq_note_t;
  localparam logic [4:0] PA = 5'h03;
  logic sys_clk, sys_rst, mdc, hostOe, hostBit, readValid;
  logic mdioOut, mdioOe, interruptN, mdioLine;
  logic [15:0] readData, live, rnd;
  logic [10:1] evt;
  logic [6:0] bitNo;
  int seed, nMismatch, totalChecks, cycles;
  phyirq_note_t notes[$];
  phyirq_note_t cur;

  // line pulled up while nobody drives it
  assign mdioLine = mdioOe ? mdioOut : (hostOe ? hostBit : 1'b1);

  phyirq_mdio_host host (.sys_clk(sys_clk), .mdioLine(mdioLine), .mdc(mdc), .hostOe(hostOe),
    .hostBit(hostBit), .readValid(readValid), .readData(readData), .bitNo(bitNo));

  phyirq_top #(.PHY_ADDR(PA)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .mdc(mdc),
    .mdioIn(mdioLine), .mdioOut(mdioOut), .mdioOe(mdioOe), .interruptN(interruptN),
    .cableDiagEvent(evt[10]), .mgmtSyncLossEvent(evt[9]), .autonegChangeEvent(evt[8]),
    .frameCheckerEvent(evt[7]), .pageReceivedEvent(evt[6]), .idleErrorSaturatedEvent(evt[5]),
    .fifoOverUnderEvent(evt[4]), .receiveChangeEvent(evt[3]), .linkChangeEvent(evt[2]),
    .speedChangeEvent(evt[1]), .standbyFlag(live[15]), .parallelDetectFaultFlag(live[14]),
    .autonegCompleteFlag(live[13]), .pairSwapDetected(live[12]), .tenPolarityInverted(live[11]),
    .resolvedTechnology(live[10:8]), .linkUp(live[7]), .txEnActive(live[6]),
    .receiveValidSeen(live[5]), .collisionActive(live[4]), .localAutonegAble(live[3]),
    .partnerAutonegAble(live[2]), .partnerAbilityPause(live[1]),
    .partnerAbilityAsymPause(live[0]));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  function automatic logic [15:0] liveWord(input logic [15:0] l);
    return {l[15], 1'b0, l[14:4], l[3] & l[2], l[1:0]};
  endfunction

  task automatic check(input string what, input logic [15:0] e, input logic [15:0] s);
    totalChecks++;
    if (s !== e) begin
      nMismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic closeOut();
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic expectRead(input logic [4:0] phy, input logic [4:0] a, input logic [15:0] v,
                            input logic [15:0] c);
    notes.push_back('{v, c});
    host.frame(OP_READ, phy, a, 16'h0000);
  endtask

  task automatic writeReg(input logic [4:0] a, input logic [15:0] v);
    host.frame(OP_WRITE, PA, a, v);
  endtask

  task automatic pulse(input int b);
    @(posedge sys_clk);
    #1;
    evt = 10'h001 << (b - 1);
    @(posedge sys_clk);
    #1;
    evt = 10'h000;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask

  // result watcher
  always @(posedge sys_clk) begin
    if (readValid === 1'b1) begin
      cur = notes.pop_front();
      check("read word", cur.value & cur.care, readData & cur.care);
    end
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 90000) begin
      nMismatch++;
      closeOut();
    end
  end

  initial begin
    seed = 89282;
    sys_rst = 1'b1;
    evt = 10'h000;
    live = 16'h0000;
    repeat (10) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    check("interruptN", 16'h0001, {15'h0000, interruptN});
    expectRead(PA, ADDR_IRQ_STATUS, 16'h0000, 16'hFFFF);
    for (int t = 0; t < 8; t++) begin
      rnd = $random(seed);
      live = {rnd[15:11], t[2:0], rnd[7:0]};
      expectRead(PA, ADDR_LIVE_STATUS, liveWord(live), 16'hFFFF);
      expectRead(PA, ADDR_LIVE_STATUS, liveWord(live), 16'hFFFF);
    end
    for (int b = 1; b <= 10; b++) begin
      pulse(b);
      expectRead(PA, ADDR_IRQ_STATUS, 16'h0001 << b, 16'hFFFF);
      expectRead(PA, ADDR_IRQ_STATUS, 16'h0000, 16'hFFFF);
    end
    writeReg(ADDR_IRQ_MASK, 16'hFFFF);
    expectRead(PA, ADDR_IRQ_MASK, 16'h07FF, 16'hFFFF);
    writeReg(ADDR_IRQ_MASK, 16'h0009);
    pulse(2);
    pulse(9);
    check("interruptN", 16'h0001, {15'h0000, interruptN});
    pulse(3);
    check("interruptN", 16'h0000, {15'h0000, interruptN});
    expectRead(PA, ADDR_IRQ_STATUS, 16'h020D, 16'hFFFF);
    check("interruptN", 16'h0001, {15'h0000, interruptN});
    writeReg(ADDR_IRQ_MASK, 16'h0008);
    pulse(3);
    check("interruptN", 16'h0001, {15'h0000, interruptN});
    expectRead(PA, ADDR_IRQ_STATUS, 16'h0009, 16'hFFFF);
    writeReg(ADDR_IRQ_MASK, 16'h0000);
    writeReg(ADDR_IRQ_STATUS, 16'hFFFF);
    writeReg(ADDR_LIVE_STATUS, ~liveWord(live));
    expectRead(PA, ADDR_IRQ_STATUS, 16'h0000, 16'hFFFF);
    expectRead(PA, ADDR_LIVE_STATUS, liveWord(live), 16'hFFFF);
    expectRead(PA, 5'h05, 16'h0000, 16'hFFFF);
    // other management address: device stays off the line
    expectRead(5'h04, ADDR_IRQ_STATUS, 16'hFFFF, 16'hFFFF);
    // event held across the clearing edge of a read
    fork
      expectRead(PA, ADDR_IRQ_STATUS, 16'h0000, 16'hFFDF);
      begin
        wait (bitNo == 7'h2F && mdc === 1'b1);
        @(posedge sys_clk);
        #1;
        evt = 10'h010;
        repeat (6) @(posedge sys_clk);
        #1;
        evt = 10'h000;
      end
    join
    expectRead(PA, ADDR_IRQ_STATUS, 16'h0020, 16'hFFFF);
    repeat (4) @(posedge sys_clk);
    check("notes left", 16'h0000, 16'(notes.size()));
    closeOut();
  end
endmodule
